// ---- sies_top.sv ----
`timescale 1ns/100ps
module sies_top #(
  parameter int FIFO_DEPTH = 16,
  parameter sies_pkg::sies_mode_e MODE = sies_pkg::SIES_STD,
  parameter int OCC_W = 8
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // shift engine events and transmit occupancy
  input wire sies_pkg::sies_evt_s I_EVT,
  input wire logic [OCC_W-1:0] I_TX_OCC,
  // select pin, active low, asynchronous
  input wire logic I_SEL_N,
  // engine control
  input wire logic [31:0] I_TX_DATA,
  output logic [31:0] O_SHIFT_LOAD,
  output logic O_START_OK,
  output logic O_IRQ
);
  ////////////////////////////////////////////////////////////////////////
  localparam logic FIFO_ON = (FIFO_DEPTH != 0);
  localparam logic STD = (MODE == sies_pkg::SIES_STD);
  localparam logic [OCC_W-1:0] HALF = OCC_W'(FIFO_DEPTH / 2);
  localparam logic [OCC_W-1:0] HALF_M1 = OCC_W'(FIFO_DEPTH / 2 - 1);

  logic [3:0] ctrl_reg;
  logic glob_en_reg;
  logic [sies_pkg::SIES_NBITS-1:0] mask_reg;
  logic [sies_pkg::SIES_NBITS-1:0] status;
  logic [sies_pkg::SIES_NBITS-1:0] set_vec;
  logic [sies_pkg::SIES_NBITS-1:0] tog_vec;
  logic [OCC_W-1:0] occ_prev_reg;
  logic sel_act;
  logic sel_prev_reg;
  logic sel_rise;
  logic enable;
  logic master;
  logic polpha_bad;
  logic underrun;

  assign enable = ctrl_reg[sies_pkg::SIES_C_ENABLE];
  assign master = ctrl_reg[sies_pkg::SIES_C_MASTER];
  assign polpha_bad = ctrl_reg[sies_pkg::SIES_C_CPOL] ^ ctrl_reg[sies_pkg::SIES_C_CPHA];

  ////////////////////////////////////////////////////////////////////////
  // select pin is asynchronous, so it is synchronised before edge detection
  sies_sync u_sel_sync (
    .i_clk(I_MCLK),
    .i_reset(I_RESET),
    .i_d(~I_SEL_N),
    .o_q(sel_act)
  );

  // select edge and previous tx occupancy
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      sel_prev_reg <= 1'b0;
      occ_prev_reg <= '0;
    end else begin
      sel_prev_reg <= sel_act;
      occ_prev_reg <= I_TX_OCC;
    end
  end
  assign sel_rise = sel_act & ~sel_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // underrun: zeros go to the shift register instead of stale data
  assign underrun = STD & ~master & enable & I_EVT.tx_req & I_EVT.tx_empty;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_SHIFT_LOAD <= 32'h0000_0000;
    end else if (I_EVT.tx_req) begin
      O_SHIFT_LOAD <= underrun ? 32'h0000_0000 : I_TX_DATA; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // set conditions for each status bit
  always_comb begin
    set_vec = '0;
    set_vec[sies_pkg::SIES_B_MMODF] = master & sel_rise; // [R19]
    // level based so it keeps setting while select stays active
    set_vec[sies_pkg::SIES_B_SMODF] = ~master & ~enable & sel_act; // [R14] [R15]
    set_vec[sies_pkg::SIES_B_TXEMPTY] = I_EVT.last_out; // [R12]
    set_vec[sies_pkg::SIES_B_UNDERRUN] = underrun & I_EVT.elem_end; // [R10]
    set_vec[sies_pkg::SIES_B_RXFULL] = I_EVT.elem_end & I_EVT.rx_write
      & (FIFO_ON ? I_EVT.rx_fills : 1'b1); // [R8] [R9]
    set_vec[sies_pkg::SIES_B_OVERRUN] = I_EVT.rx_write & I_EVT.rx_full
      & (STD | master); // [R7]
    set_vec[sies_pkg::SIES_B_TXHALF] = FIFO_ON & (occ_prev_reg == HALF)
      & (I_TX_OCC == HALF_M1); // [R5] [R6]
    set_vec[sies_pkg::SIES_B_SELECTED] = STD & ~master & sel_rise; // [R4]
    set_vec[sies_pkg::SIES_B_RXNEMPTY] = FIFO_ON & STD & ~master
      & I_EVT.rx_write & I_EVT.rx_first; // [R2] [R3]
    set_vec[sies_pkg::SIES_B_CPOLPHA] = ~STD & polpha_bad; // [R1]
  end

  assign tog_vec = (I_WR && I_ADDR == sies_pkg::SIES_STATUS_OFS)
    ? I_WDATA[sies_pkg::SIES_NBITS-1:0] : '0;

  // one sticky flag per status bit
  genvar gi;
  generate
    for (gi = 0; gi < sies_pkg::SIES_NBITS; gi++) begin : g_flag
      // flags that a build without fifos leaves out read zero and ignore toggles
      if ((gi == sies_pkg::SIES_B_RXNEMPTY || gi == sies_pkg::SIES_B_TXHALF)
          && !FIFO_ON) begin : g_zero
        assign status[gi] = 1'b0; // [R3] [R6]
      end else begin : g_live
        sies_flag u_flag (
          .i_clk(I_MCLK),
          .i_reset(I_RESET),
          .i_set(set_vec[gi]),
          .i_toggle(tog_vec[gi]),
          .o_flag(status[gi])
        );
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // software writable registers
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      ctrl_reg <= sies_pkg::SIES_CTRL_RST;
      glob_en_reg <= 1'b0;
      mask_reg <= '0;
    end else if (I_WR) begin
      case (I_ADDR)
        sies_pkg::SIES_CTRL_OFS: ctrl_reg <= I_WDATA[3:0];
        sies_pkg::SIES_GLOB_EN_OFS: glob_en_reg <= I_WDATA[sies_pkg::SIES_GLOB_EN_BIT];
        sies_pkg::SIES_MASK_OFS: mask_reg <= I_WDATA[sies_pkg::SIES_NBITS-1:0];
        default: ;
      endcase
    end
  end

  // read data one cycle later; unmapped reads return zero
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        sies_pkg::SIES_CTRL_OFS: O_RDATA <= {28'h0000000, ctrl_reg};
        sies_pkg::SIES_GLOB_EN_OFS: O_RDATA <= {glob_en_reg, 31'h00000000};
        sies_pkg::SIES_STATUS_OFS: O_RDATA <= {22'h000000, status};
        sies_pkg::SIES_MASK_OFS: O_RDATA <= {22'h000000, mask_reg};
        default: O_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt and start permission
  assign O_IRQ = glob_en_reg & |(status & mask_reg); // [R17] [R18]
  assign O_START_OK = ~(master & status[sies_pkg::SIES_B_TXEMPTY]); // [R13]

  ////////////////////////////////////////////////////////////////////////
  // checks
  // a select edge seen after the synchroniser, split by role
  sequence s_master_sel_edge;
    master && sel_act && !sel_prev_reg;
  endsequence
  sequence s_slave_sel_edge;
    STD && !master && sel_act && !sel_prev_reg;
  endsequence
  // a select held while the block sits disabled as a slave
  sequence s_idle_select;
    sel_act && !master && !enable;
  endsequence

  AST_MMODF: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R19]
    s_master_sel_edge |=> status[sies_pkg::SIES_B_MMODF])
    else $error("master fault not set");
  AST_SMODF: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R15]
    (sel_act && !master && !enable)[*2] |=> status[sies_pkg::SIES_B_SMODF])
    else $error("slave fault not held");
  AST_IRQ: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R17]
    O_IRQ |-> glob_en_reg && (status & mask_reg) != '0)
    else $error("irq without enabled status");
  AST_NOIRQ: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R18]
    !glob_en_reg |-> !O_IRQ)
    else $error("irq while global off");
  AST_TOGGLE: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R16]
    tog_vec[sies_pkg::SIES_B_TXEMPTY] && !set_vec[sies_pkg::SIES_B_TXEMPTY]
    |=> status[sies_pkg::SIES_B_TXEMPTY] != $past(status[sies_pkg::SIES_B_TXEMPTY]))
    else $error("toggle failed");
  AST_STICKY: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R20]
    status[sies_pkg::SIES_B_RXFULL] && !tog_vec[sies_pkg::SIES_B_RXFULL]
    |=> status[sies_pkg::SIES_B_RXFULL])
    else $error("flag dropped");
  AST_NOSTART: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R13]
    master && status[sies_pkg::SIES_B_TXEMPTY] |-> !O_START_OK)
    else $error("start while empty");
  AST_ZERO: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R11]
    underrun |=> O_SHIFT_LOAD == 32'h0000_0000)
    else $error("underrun data not zero");
  AST_OVR: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R7]
    I_EVT.rx_write && I_EVT.rx_full && STD |=> status[sies_pkg::SIES_B_OVERRUN])
    else $error("overrun missed");
  AST_CPOL: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R1]
    STD |-> !set_vec[sies_pkg::SIES_B_CPOLPHA])
    else $error("polarity error in standard mode");
  // the level check keeps flagging for as long as the bad setting stays
  AST_CPOL_SET: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R1]
    !STD && polpha_bad |=> status[sies_pkg::SIES_B_CPOLPHA])
    else $error("polarity error not flagged");

  // receive side flags
  AST_RXNE: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R2]
    FIFO_ON && STD && !master && I_EVT.rx_write && I_EVT.rx_first
    |=> status[sies_pkg::SIES_B_RXNEMPTY])
    else $error("receive not empty missed");
  AST_RXNE_OFF: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R3]
    !FIFO_ON |-> !status[sies_pkg::SIES_B_RXNEMPTY])
    else $error("receive not empty without fifo");
  AST_RXFULL: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R8]
    !FIFO_ON && I_EVT.elem_end && I_EVT.rx_write |=> status[sies_pkg::SIES_B_RXFULL])
    else $error("receive full missed");
  // with fifos an element end alone must not raise the full flag
  AST_RXFULL_FIFO: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R9]
    FIFO_ON && I_EVT.elem_end && !I_EVT.rx_fills
    && !status[sies_pkg::SIES_B_RXFULL] && !tog_vec[sies_pkg::SIES_B_RXFULL]
    |=> !status[sies_pkg::SIES_B_RXFULL])
    else $error("receive full before fifo filled");

  // transmit side flags
  AST_HALF: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R5]
    FIFO_ON && !$past(I_RESET) && $past(I_TX_OCC) == HALF && I_TX_OCC == HALF_M1
    |=> status[sies_pkg::SIES_B_TXHALF])
    else $error("half empty missed");
  AST_HALF_OFF: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R6]
    !FIFO_ON |-> !status[sies_pkg::SIES_B_TXHALF])
    else $error("half empty without fifo");
  AST_UNDER: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R10]
    STD && !master && enable && I_EVT.tx_req && I_EVT.tx_empty && I_EVT.elem_end
    |=> status[sies_pkg::SIES_B_UNDERRUN])
    else $error("underrun missed");
  AST_TXEMPTY: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R12]
    I_EVT.last_out |=> status[sies_pkg::SIES_B_TXEMPTY])
    else $error("transmit empty missed");
  // a slave never blocks its own transfers through the empty flag
  AST_START: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R13]
    !master |-> O_START_OK)
    else $error("start blocked in slave role");

  // select and set priority
  AST_SEL: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R4]
    s_slave_sel_edge |=> status[sies_pkg::SIES_B_SELECTED])
    else $error("slave selected missed");
  AST_SMODF_SET: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R14]
    s_idle_select |=> status[sies_pkg::SIES_B_SMODF])
    else $error("slave fault not raised");
  AST_SETWIN: assert property (@(posedge I_MCLK) disable iff (I_RESET) // [R20]
    set_vec[sies_pkg::SIES_B_OVERRUN] && tog_vec[sies_pkg::SIES_B_OVERRUN]
    |=> status[sies_pkg::SIES_B_OVERRUN])
    else $error("toggle beat a set");
endmodule : sies_top

// ---- sies_pkg.sv ----
// Contract
// R1: dual/quad mode sets clock polarity/phase error when polarity/phase bits are 01 or 10.
// R2: fifo depth 16/256, standard slave: first rx beat sets receive-not-empty flag.
// R3: without fifo receive-not-empty reads zero; no function in dual/quad mode.
// R4: standard slave only: select asserted by external master sets slave-selected flag.
// R5: standard mode: tx occupancy dropping across half depth sets half-empty flag.
// R6: dual/quad sets half-empty at configured depth's half point; only with fifos.
// R7: write into full receive store sets overrun; standard any role, dual/quad master.
// R8: without fifos, every element transfer end sets receive-full flag.
// R9: with fifos, receive-full set only when transfer end fills the fifo.
// R10: standard slave with system enable: empty-transmit request at element end sets underrun.
// R11: during underrun the shift register loads zeros and sends zeros.
// R12: transmit-empty set when final pending byte has been shifted out.
// R13: master role: no new transfer starts while transmit-empty flag is one.
// R14: slave not enabled: select becoming active sets slave mode fault immediately.
// R15: slave mode fault keeps being set while select active and device disabled.
// R16: writing one to a status bit toggles it; software clears flags this way.
// R17: interrupt output needs a set status bit with matching mask bit set.
// R18: enabled interrupts reach the output only while global enable is set.
// R19: select going active in master role sets master mode fault immediately.
// R20: a strobe sets its bit until software toggles it; set stays set.
package sies_pkg;
  // register offsets
  localparam logic [7:0] SIES_GLOB_EN_OFS = 8'h1c;
  localparam logic [7:0] SIES_STATUS_OFS = 8'h20;
  localparam logic [7:0] SIES_MASK_OFS = 8'h28;
  localparam logic [7:0] SIES_CTRL_OFS = 8'h60;
  // status bit positions
  localparam int SIES_NBITS = 10;
  localparam int SIES_B_MMODF = 0;
  localparam int SIES_B_SMODF = 1;
  localparam int SIES_B_TXEMPTY = 2;
  localparam int SIES_B_UNDERRUN = 3;
  localparam int SIES_B_RXFULL = 4;
  localparam int SIES_B_OVERRUN = 5;
  localparam int SIES_B_TXHALF = 6;
  localparam int SIES_B_SELECTED = 7;
  localparam int SIES_B_RXNEMPTY = 8;
  localparam int SIES_B_CPOLPHA = 9;
  // control register fields
  localparam int SIES_C_ENABLE = 0;
  localparam int SIES_C_MASTER = 1;
  localparam int SIES_C_CPHA = 2;
  localparam int SIES_C_CPOL = 3;
  localparam int SIES_GLOB_EN_BIT = 31;
  // reset values
  localparam logic [SIES_NBITS-1:0] SIES_STATUS_RST = 10'h000;
  localparam logic [3:0] SIES_CTRL_RST = 4'h0;
  // configured bus width mode
  typedef enum logic [1:0] {SIES_STD, SIES_DUAL, SIES_QUAD} sies_mode_e;
  // events from the shift engine, one-cycle strobes on the bus clock
  typedef struct packed {
    logic rx_write;      // transfer logic writes a received element
    logic rx_first;      // first element of a transaction
    logic rx_full;       // receive store full before the write
    logic rx_fills;      // this write leaves the fifo full
    logic elem_end;      // element transfer ended
    logic tx_req;        // element requested from transmit store
    logic tx_empty;      // transmit store empty at request
    logic last_out;      // last pending byte shifted out
  } sies_evt_s;
endpackage : sies_pkg

// ---- sies_sync.sv ----
`timescale 1ns/100ps
// two-stage synchroniser for a level from a pin
module sies_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // level
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  // first stage is read only by the second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule : sies_sync

// ---- sies_flag.sv ----
`timescale 1ns/100ps
// one sticky status bit: hardware set wins over a software toggle
module sies_flag (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // set and toggle
  input wire logic i_set,
  input wire logic i_toggle,
  output logic o_flag
);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1; // [R20]
    end else if (i_toggle) begin
      o_flag <= ~o_flag; // [R16]
    end
  end
endmodule : sies_flag

// ---- sies_irq_sink.sv ----
`timescale 1ns/100ps
// interrupt controller side: counts rising edges of the request line
module sies_irq_sink (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // request from the block
  input wire logic i_irq,
  output int o_edges
);
  logic irq_reg;
  // a level that stays up counts once, as a real edge-capturing controller would
  always_ff @(posedge i_clk) begin
    irq_reg <= i_reset ? 1'b0 : i_irq;
    if (i_reset) o_edges <= 0;
    else if (i_irq && !irq_reg) o_edges <= o_edges + 1;
  end
endmodule : sies_irq_sink

// ---- spi_interrupt_status_events_bench.sv ----
`timescale 1ns/100ps
module spi_interrupt_status_events_bench;
  logic I_MCLK = 1'b0, I_RESET = 1'b1, I_WR = 1'b0, I_RD = 1'b0, I_SEL_N = 1'b1;
  logic [7:0] I_ADDR = 8'h00, I_TX_OCC = 8'h00;
  logic [31:0] I_WDATA = 32'h0, I_TX_DATA = 32'h0;
  sies_pkg::sies_evt_s I_EVT = '0;
  logic [31:0] O_RDATA, O_SHIFT_LOAD, alt_rdata;
  logic O_START_OK, O_IRQ;
  int fail_count = 0, num_checks = 0, cyc = 0, edges;
  sies_top #(.FIFO_DEPTH(16), .MODE(sies_pkg::SIES_STD), .OCC_W(8)) dut (.I_MCLK(I_MCLK),
    .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .I_EVT(I_EVT), .I_TX_OCC(I_TX_OCC), .I_SEL_N(I_SEL_N),
    .I_TX_DATA(I_TX_DATA), .O_SHIFT_LOAD(O_SHIFT_LOAD), .O_START_OK(O_START_OK), .O_IRQ(O_IRQ));
  // a dual-mode core built without fifos sees the same bus and events
  sies_top #(.FIFO_DEPTH(0), .MODE(sies_pkg::SIES_DUAL), .OCC_W(8)) dut_alt (
    .I_MCLK(I_MCLK),
    .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(alt_rdata), .I_EVT(I_EVT), .I_TX_OCC(I_TX_OCC), .I_SEL_N(I_SEL_N),
    .I_TX_DATA(I_TX_DATA), .O_SHIFT_LOAD(), .O_START_OK(), .O_IRQ());
  sies_irq_sink sink (.i_clk(I_MCLK), .i_reset(I_RESET), .i_irq(O_IRQ), .o_edges(edges));
  ////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    forever #50 I_MCLK = ~I_MCLK;
  end
  // hang guard: all tests take well under a thousand cycles
  always @(posedge I_MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // single-cycle write strobe, dropped at the following edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 chk(O_RDATA, exp);
  endtask : rd
  // one read seen by both cores, each held against its own build
  task automatic rd2(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] exp_alt);
    rd(a, exp);
    chk(alt_rdata, exp_alt);
  endtask : rd2
  task automatic pulse(input sies_pkg::sies_evt_s e);
    @(posedge I_MCLK);
    I_EVT <= e;
    @(posedge I_MCLK);
    I_EVT <= '0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  task automatic t_overrun_irq();
    sies_pkg::sies_evt_s e;
    e = '0;
    e.rx_write = 1'b1;
    e.rx_full = 1'b1;
    pulse(e);
    pulse(e);
    rd(8'h20, 32'h020);
    wr(8'h28, 32'h020);
    rd(8'h28, 32'h020);
    #1 chk(O_IRQ, 1'b0);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h80000000);
    #1 chk(O_IRQ, 1'b1);
    wr(8'h28, 32'h010);
    #1 chk(O_IRQ, 1'b0);
    wr(8'h28, 32'h020);
    wr(8'h20, 32'h020);
    rd(8'h20, 32'h000);
    #1 chk(O_IRQ, 1'b0);
    wr(8'h1c, 32'h0);
    $display("test overrun and interrupt done");
  endtask : t_overrun_irq
  task automatic t_receive();
    sies_pkg::sies_evt_s e;
    e = '0;
    e.rx_write = 1'b1;
    e.elem_end = 1'b1;
    pulse(e);
    rd(8'h20, 32'h000);
    e.rx_fills = 1'b1;
    pulse(e);
    rd(8'h20, 32'h010);
    e = '0;
    e.rx_write = 1'b1;
    e.rx_first = 1'b1;
    pulse(e);
    rd(8'h20, 32'h110);
    wr(8'h20, 32'h110);
    $display("test receive done");
  endtask : t_receive
  task automatic t_transmit();
    sies_pkg::sies_evt_s e;
    wr(8'h60, 32'h1);
    e = '0;
    e.tx_req = 1'b1;
    I_TX_DATA <= 32'h5a5ac3c3;
    pulse(e);
    #1 chk(O_SHIFT_LOAD, 32'h5a5ac3c3);
    e.tx_empty = 1'b1;
    e.elem_end = 1'b1;
    pulse(e);
    #1 chk(O_SHIFT_LOAD, 32'h0);
    rd(8'h20, 32'h008);
    wr(8'h20, 32'h008);
    // occupancy steps down one value at a time, 9 then 8 then 7; only 8 to 7 may strobe the flag
    @(posedge I_MCLK);
    I_TX_OCC <= 8'h09;
    @(posedge I_MCLK);
    I_TX_OCC <= 8'h08;
    rd(8'h20, 32'h000);
    @(posedge I_MCLK);
    I_TX_OCC <= 8'h07;
    rd(8'h20, 32'h040);
    wr(8'h20, 32'h040);
    wr(8'h60, 32'h2);
    e = '0;
    e.last_out = 1'b1;
    pulse(e);
    rd(8'h20, 32'h004);
    #1 chk(O_START_OK, 1'b0);
    wr(8'h20, 32'h004);
    #1 chk(O_START_OK, 1'b1);
    $display("test transmit done");
  endtask : t_transmit
  // select path runs through a two-flop synchroniser, hence the settle waits
  task automatic t_select();
    wr(8'h60, 32'h0);
    @(posedge I_MCLK);
    I_SEL_N <= 1'b0;
    repeat (6) @(posedge I_MCLK);
    rd(8'h20, 32'h082);
    wr(8'h20, 32'h082);
    rd(8'h20, 32'h002);
    @(posedge I_MCLK);
    I_SEL_N <= 1'b1;
    repeat (6) @(posedge I_MCLK);
    wr(8'h20, 32'h002);
    wr(8'h60, 32'h2);
    I_SEL_N <= 1'b0;
    repeat (6) @(posedge I_MCLK);
    rd(8'h20, 32'h001);
    $display("test select done");
  endtask : t_select
  // mid-run reset, then one event set into both builds side by side
  task automatic t_modes();
    sies_pkg::sies_evt_s e;
    @(posedge I_MCLK);
    I_RESET <= 1'b1;
    I_SEL_N <= 1'b1;
    repeat (2) @(posedge I_MCLK);
    I_RESET <= 1'b0;
    rd2(8'h20, 32'h000, 32'h000);
    e = '0;
    e.rx_write = 1'b1;
    e.rx_first = 1'b1;
    e.rx_full = 1'b1;
    e.elem_end = 1'b1;
    pulse(e);
    @(posedge I_MCLK);
    I_TX_OCC <= 8'h08;
    @(posedge I_MCLK);
    I_TX_OCC <= 8'h07;
    wr(8'h60, 32'h4);
    rd2(8'h20, 32'h160, 32'h210);
    wr(8'h20, 32'h140);
    rd2(8'h20, 32'h020, 32'h210);
    $display("test modes done");
  endtask : t_modes
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge I_MCLK);
    I_RESET <= 1'b0;
    rd(8'h20, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h44, 32'h0);
    chk(O_START_OK, 1'b1);
    $display("test reset done");
    t_overrun_irq();
    t_receive();
    t_transmit();
    t_select();
    // the request rose twice: once on the global enable, once on re-enabling the mask
    chk(edges, 32'h2);
    t_modes();
    stop_test();
  end
endmodule : spi_interrupt_status_events_bench
